//--- mrad_defs.vh
`ifndef MRAD_DEFS_VH
`define MRAD_DEFS_VH

// geometry
`define MRAD_NUM_REGIONS   12
`define MRAD_IDX_W         4
`define MRAD_ATTR_W        7
`define MRAD_ADDR_W        8

// register byte offsets
`define MRAD_OFF_REGION0   8'h00
`define MRAD_OFF_CTRL      8'h30
`define MRAD_OFF_STATUS    8'h34
`define MRAD_OFF_LAST      8'h38

// region attribute word fields
`define MRAD_F_INNER_LO    0
`define MRAD_F_INNER_HI    1
`define MRAD_F_TYPEXT_LSB  2
`define MRAD_F_SHARE       5
`define MRAD_F_NOFETCH     6
`define MRAD_REGION_RESET  7'h00

// control and status fields
`define MRAD_F_L1EN        0
`define MRAD_CTRL_RESET    1'h1
`define MRAD_F_SOBUSY      0
`define MRAD_F_RSVHIT      1
`define MRAD_F_FETCHREF    2

// memory types
`define MRAD_MT_SO         2'h0
`define MRAD_MT_DEV        2'h1
`define MRAD_MT_NORM       2'h2

// cache policy codes, shared by inner and outer
`define MRAD_POL_NC        2'h0
`define MRAD_POL_WBWA      2'h1
`define MRAD_POL_WT        2'h2
`define MRAD_POL_WB        2'h3

// bus cache attribute values
`define MRAD_CA_SO         4'h0
`define MRAD_CA_DEV        4'h1
`define MRAD_CA_NC         4'h3
`define MRAD_CA_WT         4'h6
`define MRAD_CA_WB         4'h7
`define MRAD_CA_WBWA       4'hF

`endif

//--- mrad_type_decode.v
`include "mrad_defs.vh"

module mrad_type_decode (
    // stored region fields
    input  wire [2:0] typeExt,
    input  wire       innerHi,
    input  wire       innerLo,
    input  wire       shareFlag,
    input  wire       tcmHit,
    // decoded attributes
    output reg  [1:0] memType,
    output reg        shareable,
    output reg  [1:0] innerPol,
    output reg  [1:0] outerPol,
    output reg        readAlloc,
    output reg        writeAlloc,
    output reg        reservedHit
);
    wire [1:0] ib;
    assign ib = {innerHi, innerLo};

    always @* begin
        memType     = `MRAD_MT_SO;
        innerPol    = `MRAD_POL_NC;
        outerPol    = `MRAD_POL_NC;
        reservedHit = 1'b0;
        if (typeExt[2]) begin
            memType  = `MRAD_MT_NORM;
            innerPol = ib;
            outerPol = typeExt[1:0];
        end else begin
            case ({typeExt[1:0], ib})
                4'h0: memType = `MRAD_MT_SO;
                4'h1: memType = `MRAD_MT_DEV;
                4'h2: begin
                    memType  = `MRAD_MT_NORM;
                    innerPol = `MRAD_POL_WT;
                    outerPol = `MRAD_POL_WT;
                end
                4'h3: begin
                    memType  = `MRAD_MT_NORM;
                    innerPol = `MRAD_POL_WB;
                    outerPol = `MRAD_POL_WB;
                end
                4'h4: memType = `MRAD_MT_NORM;
                4'h7: begin
                    memType  = `MRAD_MT_NORM;
                    innerPol = `MRAD_POL_WBWA;
                    outerPol = `MRAD_POL_WBWA;
                end
                4'h8: memType = `MRAD_MT_DEV;
                default: reservedHit = 1'b1;
            endcase
        end
        // tcm space is normal non-shared, uncached on the bus side
        if (tcmHit) begin
            memType  = `MRAD_MT_NORM;
            innerPol = `MRAD_POL_NC;
            outerPol = `MRAD_POL_NC;
        end
        // sharing: forced for SO, fixed for device, flag for normal
        if (tcmHit)
            shareable = 1'b0;
        else if (memType == `MRAD_MT_SO)
            shareable = 1'b1;
        else if (memType == `MRAD_MT_DEV)
            shareable = ({typeExt[1:0], ib} == 4'h1);
        else
            shareable = shareFlag;
        readAlloc  = (innerPol != `MRAD_POL_NC);
        writeAlloc = (innerPol == `MRAD_POL_WBWA);
    end
endmodule // mrad_type_decode

//--- mrad_order_gate.v
`include "mrad_defs.vh"

module mrad_order_gate (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // access being offered
    input  wire       accValid,
    input  wire       accRead,
    input  wire [1:0] memType,
    input  wire       accDone,
    // store buffer state
    input  wire       sbEmpty,
    input  wire       sbDevEmpty,
    // gate outputs
    output wire       accReady,
    output wire       drainAll,
    output wire       drainDevice,
    output reg        soBusy
);
    wire isSo;
    wire isDev;
    wire soOk;
    wire devOk;

    assign isSo  = (memType == `MRAD_MT_SO);
    assign isDev = (memType == `MRAD_MT_DEV);
    // one strongly ordered access in flight keeps program order
    assign soOk  = sbEmpty && !soBusy;
    assign devOk = !accRead || sbDevEmpty;
    assign accReady = isSo ? soOk : (isDev ? devOk : 1'b1);
    assign drainAll = accValid && isSo && !sbEmpty;
    assign drainDevice = accValid && isDev && accRead && !sbDevEmpty;

    always @(posedge clk or posedge rst) begin
        if (rst)
            soBusy <= 1'b0;
        else if (accValid && accReady && isSo)
            soBusy <= 1'b1; // a new issue wins over a done
        else if (accDone)
            soBusy <= 1'b0;
    end
endmodule // mrad_order_gate

//--- mrad_decoder.v
// Functional notes
// - each region has exactly one type: strongly ordered, device or normal
// - every region holds its own type attribute, applied to its accesses
// - strongly ordered accesses complete in program order, never reordered
// - strongly ordered accesses are always shareable
// - L1 cache neither allocates nor hits for shareable normal regions
// - device reads wait until store buffer holds no device writes
// - strongly ordered accesses wait until store buffer is completely empty
// - region type is three extension bits plus two inner bits
// - every inner-cacheable region is also read-allocate
// - sharing flag applies to normal regions only, 1 shared, 0 not
// - extension 000: SO, shared device, normal WT, normal WB
// - extension 001: normal uncached, 11 WB write-allocate, others reserved
// - extension 010 00 non-shared device; 010 others and 011 reserved
// - top extension bit set: normal, outer policy from low extension bits, inner from inner bits
// - policy code: 00 NC, 01 WBWA, 10 WT, 11 WB
// - inner attributes drive the per-channel user sideband outputs
// - outer attributes drive the per-channel cache attribute outputs
// - fetches from device or SO regions refused as if no-fetch set
// - tcm addresses get normal non-shared attributes, permissions kept
`include "mrad_defs.vh"

module mrad_decoder (
    // clock and reset
    input  wire                    clk,
    input  wire                    rst,
    // avalon-mm slave
    input  wire [`MRAD_ADDR_W-1:0] avs_address,
    input  wire                    avs_read,
    input  wire                    avs_write,
    input  wire [31:0]             avs_writedata,
    input  wire [3:0]              avs_byteenable,
    output reg  [31:0]             avs_readdata,
    output wire                    avs_waitrequest,
    // access from load/store and fetch path
    input  wire                    accValid,
    input  wire                    accRead,
    input  wire                    accFetch,
    input  wire                    matchValid,
    input  wire [`MRAD_IDX_W-1:0]  matchIdx,
    input  wire                    tcmHit,
    input  wire                    accDone,
    output wire                    accReady,
    output wire                    accIssue,
    // store buffer
    input  wire                    sbEmpty,
    input  wire                    sbDevEmpty,
    output wire                    drainAll,
    output wire                    drainDevice,
    // decoded attributes
    output wire [1:0]              memType,
    output wire                    shareable,
    output wire [1:0]              innerPol,
    output wire [1:0]              outerPol,
    output wire                    readAlloc,
    output wire                    writeAlloc,
    output wire                    l1Cacheable,
    output wire                    fetchRefuse,
    // axi master sideband
    output wire [2:0]              busInnerAttrOutAr,
    output wire [2:0]              busInnerAttrOutAw,
    output wire [3:0]              busOuterAttrOutAr,
    output wire [3:0]              busOuterAttrOutAw
);
    localparam NR = `MRAD_NUM_REGIONS;
    localparam AW = `MRAD_ATTR_W;

    ////////////////////////////////////////////////////////////////////////
    // bus slave front end
    reg  busAck;
    wire busReq;
    wire busWr;
    wire busRd;
    wire [5:0] wordIdx;
    wire regionHit;

    assign busReq = avs_read || avs_write;
    // one wait cycle, then the answer edge
    assign avs_waitrequest = busReq && !busAck;
    assign busWr = avs_write && busAck;
    assign busRd = avs_read && !busAck;
    assign wordIdx = avs_address[7:2];
    assign regionHit = (wordIdx < NR[5:0]);

    always @(posedge clk or posedge rst) begin
        if (rst)
            busAck <= 1'b0;
        else
            busAck <= busReq && !busAck;
    end

    ////////////////////////////////////////////////////////////////////////
    // per-region attribute registers
    wire [NR*AW-1:0] regionVec;

    genvar g;
    generate
        for (g = 0; g < NR; g = g + 1) begin : gRegion
            reg [AW-1:0] attr;
            always @(posedge clk or posedge rst) begin
                if (rst)
                    attr <= `MRAD_REGION_RESET;
                else if (busWr && avs_byteenable[0] && wordIdx == g)
                    attr <= avs_writedata[AW-1:0];
            end
            assign regionVec[g*AW +: AW] = attr;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control register
    reg l1En;

    always @(posedge clk or posedge rst) begin
        if (rst)
            l1En <= `MRAD_CTRL_RESET;
        else if (busWr && avs_byteenable[0] && avs_address == `MRAD_OFF_CTRL)
            l1En <= avs_writedata[`MRAD_F_L1EN];
    end

    ////////////////////////////////////////////////////////////////////////
    // matched region lookup
    wire          idxOk;
    wire [AW-1:0] selAttr;
    wire          noFetch;

    // out-of-range or missing match falls back to the all-zero encoding,
    // which decodes as strongly ordered: the safest ordering
    assign idxOk = matchValid && (matchIdx < NR[`MRAD_IDX_W-1:0]);
    assign selAttr = idxOk ? regionVec[matchIdx*AW +: AW] : {AW{1'b0}};
    assign noFetch = selAttr[`MRAD_F_NOFETCH];

    wire rsvHit;

    mrad_type_decode uDecode (
        .typeExt     (selAttr[`MRAD_F_TYPEXT_LSB +: 3]),
        .innerHi     (selAttr[`MRAD_F_INNER_HI]),
        .innerLo     (selAttr[`MRAD_F_INNER_LO]),
        .shareFlag   (selAttr[`MRAD_F_SHARE]),
        .tcmHit      (tcmHit),
        .memType     (memType),
        .shareable   (shareable),
        .innerPol    (innerPol),
        .outerPol    (outerPol),
        .readAlloc   (readAlloc),
        .writeAlloc  (writeAlloc),
        .reservedHit (rsvHit)
    );

    ////////////////////////////////////////////////////////////////////////
    // cacheability and fetch checks
    wire isNormal;

    assign isNormal = (memType == `MRAD_MT_NORM);
    // shared normal data would go stale between masters, so L1 keeps out
    assign l1Cacheable = l1En && isNormal && !shareable && readAlloc;
    // the tcm override makes the space normal, so only its flag can refuse
    assign fetchRefuse = accValid && accFetch && (noFetch || !isNormal);

    ////////////////////////////////////////////////////////////////////////
    // ordering gate
    wire gateReady;
    wire soBusy;

    mrad_order_gate uOrder (
        .clk         (clk),
        .rst         (rst),
        .accValid    (accValid && !fetchRefuse),
        .accRead     (accRead || accFetch),
        .memType     (memType),
        .accDone     (accDone),
        .sbEmpty     (sbEmpty),
        .sbDevEmpty  (sbDevEmpty),
        .accReady    (gateReady),
        .drainAll    (drainAll),
        .drainDevice (drainDevice),
        .soBusy      (soBusy)
    );

    // a refused fetch is answered at once and never reaches the bus
    assign accReady = gateReady || fetchRefuse;
    assign accIssue = accValid && gateReady && !fetchRefuse;

    ////////////////////////////////////////////////////////////////////////
    // axi sideband attributes
    reg [3:0] cacheAttr;

    always @* begin
        case (memType)
            `MRAD_MT_SO:  cacheAttr = `MRAD_CA_SO;
            `MRAD_MT_DEV: cacheAttr = `MRAD_CA_DEV;
            default: begin
                case (outerPol)
                    `MRAD_POL_WBWA: cacheAttr = `MRAD_CA_WBWA;
                    `MRAD_POL_WT:   cacheAttr = `MRAD_CA_WT;
                    `MRAD_POL_WB:   cacheAttr = `MRAD_CA_WB;
                    default:        cacheAttr = `MRAD_CA_NC;
                endcase
            end
        endcase
    end

    wire issueRd;
    wire issueWr;
    wire [2:0] innerUser;

    assign issueRd = accIssue && (accRead || accFetch);
    assign issueWr = accIssue && !(accRead || accFetch);
    assign innerUser = {shareable, innerPol};
    // idle channels show zero so stale attributes never leak
    assign busInnerAttrOutAr = issueRd ? innerUser : 3'h0;
    assign busInnerAttrOutAw = issueWr ? innerUser : 3'h0;
    assign busOuterAttrOutAr = issueRd ? cacheAttr : 4'h0;
    assign busOuterAttrOutAw = issueWr ? cacheAttr : 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // status: sticky events and last issued attributes
    reg       rsvSticky;
    reg       fetchSticky;
    reg [9:0] lastAttr;
    wire      stClr;

    assign stClr = busWr && avs_byteenable[0] && avs_address == `MRAD_OFF_STATUS;

    // a new event in the clearing cycle wins over the write-one-to-clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rsvSticky   <= 1'b0;
            fetchSticky <= 1'b0;
        end else begin
            if (accIssue && rsvHit && !tcmHit)
                rsvSticky <= 1'b1;
            else if (stClr && avs_writedata[`MRAD_F_RSVHIT])
                rsvSticky <= 1'b0;
            if (fetchRefuse)
                fetchSticky <= 1'b1;
            else if (stClr && avs_writedata[`MRAD_F_FETCHREF])
                fetchSticky <= 1'b0;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            lastAttr <= 10'h000;
        else if (accIssue)
            lastAttr <= {l1Cacheable, writeAlloc, readAlloc, outerPol,
                         innerPol, shareable, memType};
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, taken in the wait cycle and held through the answer edge
    reg [31:0] next_readdata;

    always @* begin
        next_readdata = 32'h0000_0000;
        if (regionHit)
            next_readdata[AW-1:0] = regionVec[wordIdx[3:0]*AW +: AW];
        else if (avs_address == `MRAD_OFF_CTRL)
            next_readdata[`MRAD_F_L1EN] = l1En;
        else if (avs_address == `MRAD_OFF_STATUS) begin
            next_readdata[`MRAD_F_SOBUSY]   = soBusy;
            next_readdata[`MRAD_F_RSVHIT]   = rsvSticky;
            next_readdata[`MRAD_F_FETCHREF] = fetchSticky;
        end else if (avs_address == `MRAD_OFF_LAST)
            next_readdata[9:0] = lastAttr;
    end

    always @(posedge clk or posedge rst) begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (busRd)
            avs_readdata <= next_readdata;
    end
endmodule // mrad_decoder

//--- mrad_sb_model.sv
module mrad_sb_model (
    // clock and reset
    input  logic clk,
    input  logic rst,
    // stimulus from the bench
    input  logic sbPush,
    input  logic sbPushDev,
    input  logic slow,
    // requests from the decoder
    input  logic drainAll,
    input  logic drainDevice,
    input  logic soIssue,
    // store buffer and bus state
    output logic sbEmpty,
    output logic sbDevEmpty,
    output logic accDone
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] nAll, nDev, tmr;
    logic [1:0] ph;
    assign sbEmpty    = nAll == 4'h0;
    assign sbDevEmpty = nDev == 4'h0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            {nAll, nDev, tmr, ph, accDone} <= '0;
        end else begin
            ph      <= ph + 2'h1;
            // one outstanding ordered access, completion late when slow
            accDone <= tmr == 4'h1;
            if (soIssue) tmr <= slow ? 4'h6 : 4'h2;
            else if (tmr != 4'h0) tmr <= tmr - 4'h1;
            // drains only on request, every fourth cycle when slow
            if (sbPush) begin
                nAll <= nAll + 4'h1;
                nDev <= nDev + {3'h0, sbPushDev};
            end else if ((drainAll || drainDevice) && !sbEmpty && (!slow || ph == 2'h0)) begin
                nAll <= nAll - 4'h1;
                if (!sbDevEmpty) nDev <= nDev - 4'h1;
            end
        end
    end
endmodule // mrad_sb_model

//--- mrad_decoder_props.sv
`include "mrad_defs.vh"
module mrad_decoder_props (
    // clock and reset
    input logic       clk,
    input logic       rst,
    // access path
    input logic       accValid,
    input logic       accRead,
    input logic       accFetch,
    input logic       tcmHit,
    input logic       accDone,
    input logic       accIssue,
    input logic       accReady,
    input logic       sbEmpty,
    input logic       sbDevEmpty,
    input logic       drainAll,
    input logic       drainDevice,
    // attributes
    input logic [1:0] memType,
    input logic       shareable,
    input logic [1:0] innerPol,
    input logic [1:0] outerPol,
    input logic       readAlloc,
    input logic       l1Cacheable,
    input logic       fetchRefuse,
    // bus sideband
    input logic [2:0] busInnerAttrOutAr,
    input logic [2:0] busInnerAttrOutAw,
    input logic [3:0] busOuterAttrOutAr,
    input logic [3:0] busOuterAttrOutAw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       soOut, soIss, rdIss, wrIss;
    logic [3:0] oExp;
    assign soIss = accIssue && memType == `MRAD_MT_SO;
    assign rdIss = accIssue && (accRead || accFetch);
    assign wrIss = accIssue && !(accRead || accFetch);
    assign oExp  = memType == `MRAD_MT_SO ? `MRAD_CA_SO : memType == `MRAD_MT_DEV ? `MRAD_CA_DEV :
                   outerPol == `MRAD_POL_NC ? `MRAD_CA_NC : outerPol == `MRAD_POL_WT ? `MRAD_CA_WT :
                   outerPol == `MRAD_POL_WB ? `MRAD_CA_WB : `MRAD_CA_WBWA;
    always @(posedge clk or posedge rst) begin
        if (rst) soOut <= 1'b0;
        else if (soIss) soOut <= 1'b1;
        else if (accDone) soOut <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    so_drain_a: assert property (accValid && !accFetch && memType == `MRAD_MT_SO && !sbEmpty
        |-> drainAll && !accIssue) else $error("ordered access not held for drain");
    so_gate_a: assert property (soIss |-> sbEmpty) else $error("ordered access with pending stores");
    so_order_a: assert property (soIss |-> !soOut) else $error("second ordered access too early");
    so_ready_a: assert property (accValid && !accFetch && memType == `MRAD_MT_SO && sbEmpty && !soOut
        |-> accIssue) else $error("ordered access stalled");
    dev_drain_a: assert property (accValid && accRead && !accFetch && memType == `MRAD_MT_DEV && !sbDevEmpty
        |-> drainDevice && !accIssue) else $error("device read passed device stores");
    so_share_a: assert property (memType == `MRAD_MT_SO |-> shareable) else $error("ordered not shareable");
    so_stall_a: assert property (accValid && !accFetch && memType == `MRAD_MT_SO && !sbEmpty |-> !accReady)
        else $error("ordered access ready with pending stores");
    ready_issue_a: assert property (accValid && accReady && !fetchRefuse |-> accIssue)
        else $error("ready access not issued");
    l1_share_a: assert property (l1Cacheable |-> memType == `MRAD_MT_NORM && !shareable)
        else $error("shared region cached");
    read_alloc_a: assert property (memType == `MRAD_MT_NORM && innerPol != `MRAD_POL_NC |-> readAlloc)
        else $error("cacheable without read allocate");
    fetch_ref_a: assert property (accValid && accFetch && memType != `MRAD_MT_NORM |-> fetchRefuse && !accIssue)
        else $error("fetch from device not refused");
    tcm_attr_a: assert property (tcmHit |-> memType == `MRAD_MT_NORM && !shareable)
        else $error("tcm attributes wrong");
    inner_band_a: assert property (busInnerAttrOutAr == (rdIss ? {shareable, innerPol} : 3'h0) &&
        busInnerAttrOutAw == (wrIss ? {shareable, innerPol} : 3'h0)) else $error("inner sideband wrong");
    outer_band_a: assert property (busOuterAttrOutAr == (rdIss ? oExp : 4'h0) &&
        busOuterAttrOutAw == (wrIss ? oExp : 4'h0)) else $error("outer sideband wrong");
endmodule // mrad_decoder_props
bind mrad_decoder mrad_decoder_props u_props (.*);

//--- mrad_decoder_test.sv
`include "mrad_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module mrad_decoder_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, rst = 1, avs_read = 0, avs_write = 0, chk = 0, slow = 0;
    logic        accValid = 0, accRead = 0, accFetch = 0, matchValid = 0, tcmHit = 0;
    logic        sbPush = 0, sbPushDev = 0, avs_waitrequest, accReady, accIssue, drainAll, drainDevice;
    logic        sbEmpty, sbDevEmpty, accDone, shareable, readAlloc, writeAlloc, l1Cacheable, fetchRefuse;
    logic [7:0]  avs_address = 0;
    logic [31:0] avs_writedata = 0, avs_readdata, g, rnd = 32'h7FFF;
    logic [3:0]  avs_byteenable = 0, matchIdx = 0, busOuterAttrOutAr, busOuterAttrOutAw;
    logic [1:0]  memType, innerPol, outerPol;
    logic [2:0]  busInnerAttrOutAr, busInnerAttrOutAw;
    logic [63:0] e, q[$];
    logic [6:0]  regVal [12];
    localparam logic [6:0] PROG [4] = '{7'h00, 7'h01, 7'h03, 7'h05};
    int          err_count = 0, n_tests = 0, i, k;
    wire         soIssue = accIssue && memType == `MRAD_MT_SO;
    mrad_decoder DUT (.*);
    mrad_sb_model u_sb (.*);
    always #2.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [13:0] dec(input [6:0] w, input t);
        reg [2:0] x;
        reg [1:0] n, p;
        begin
            x = w[4:2];
            n = w[1:0];
            p = (x == 3'h1 && n == 2'h3) ? `MRAD_POL_WBWA : n;
            if (t) dec = {7'h7F, `MRAD_POL_NC, `MRAD_POL_NC, 1'b0, `MRAD_MT_NORM};
            else if (x[2]) dec = {7'h7F, x[1:0], n, w[5], `MRAD_MT_NORM};
            else if ((x == 3'h0 && n[1]) || (x == 3'h1 && (n == 2'h0 || n == 2'h3)))
                dec = {7'h7F, p, p, w[5], `MRAD_MT_NORM};
            else if (x == 3'h0 && n == 2'h1) dec = {7'h07, 4'h0, 1'b1, `MRAD_MT_DEV};
            else if (x == 3'h2 && n == 2'h0) dec = {7'h07, 4'h0, 1'b0, `MRAD_MT_DEV};
            else dec = {7'h07, 4'h0, 1'b1, `MRAD_MT_SO};
        end
    endfunction
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    task tmo;
        begin
            err_count++;
            $display("BAD t=%0t wait expired", $time);
            wrap_up;
        end
    endtask
    // request held until the edge after waitrequest is seen low
    task bus(input rd, input [7:0] a, input [31:0] d, input [3:0] be, input [31:0] m, input [31:0] x);
        int n;
        begin
            @(posedge clk);
            if (rd) q.push_back({m, x});
            avs_address <= a;
            avs_read <= rd;
            avs_write <= !rd;
            avs_writedata <= d;
            avs_byteenable <= be;
            n = 0;
            do begin @(negedge clk); n++; end while (avs_waitrequest && n < 20);
            if (avs_waitrequest) tmo;
            else begin @(posedge clk); avs_read <= 0; avs_write <= 0; end
        end
    endtask
    task dchk(input [3:0] idx, input t, input [13:0] d);
        begin
            @(posedge clk);
            matchIdx <= idx;
            matchValid <= 1;
            tcmHit <= t;
            chk <= 1;
            q.push_back({25'h0, d[13:7], 25'h0, d[6:0]});
            @(posedge clk);
            chk <= 0;
        end
    endtask
    task iss(input [3:0] idx, input rd, input f);
        int n;
        begin
            @(posedge clk);
            {accValid, accRead, accFetch, matchIdx, matchValid, tcmHit} <= {1'b1, rd, f, idx, 2'b10};
            n = 0;
            do begin @(negedge clk); n++; end while (!(accIssue || fetchRefuse) && n < 50);
            if (!(accIssue || fetchRefuse)) tmo;
            else begin @(posedge clk); accValid <= 0; end
        end
    endtask
    task sbp(input dev);
        begin
            @(posedge clk);
            sbPush <= 1;
            sbPushDev <= dev;
            @(posedge clk);
            sbPush <= 0;
            sbPushDev <= 0;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        if (!rst && ((avs_read && !avs_waitrequest) || chk) && q.size() > 0) begin
            e = q.pop_front();
            g = chk ? {25'h0, outerPol, innerPol, shareable, memType} : avs_readdata;
            `CHK(g & e[63:32], e[31:0])
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        bus(1, `MRAD_OFF_CTRL, 0, 0, 32'h1, 32'h1);
        bus(1, `MRAD_OFF_STATUS, 0, 0, 32'h7, 32'h0);
        bus(1, 8'h14, 0, 0, 32'h7F, 32'h0);
        // every type encoding with both sharing values
        for (i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            k = i % 12;
            regVal[k] = {rnd[0], i[5:0]};
            bus(0, 8'(k * 4), {25'h0, regVal[k]}, {3'h0, 1'b1}, 0, 0);
            dchk(4'(k), &rnd[3:1], dec(regVal[k], &rnd[3:1]));
        end
        bus(0, `MRAD_OFF_REGION0, 32'h7F, 4'h0, 0, 0);
        for (k = 0; k < 12; k++) bus(1, 8'(k * 4), 0, 0, 32'h7F, {25'h0, regVal[k]});
        bus(0, 8'h3C, 32'hFFFFFFFF, 4'hF, 0, 0);
        bus(1, 8'h3C, 0, 0, 32'hFFFFFFFF, 32'h0);
        for (k = 0; k < 4; k++) bus(0, 8'(k * 4), {25'h0, PROG[k]}, 4'h1, 0, 0);
        // ordered accesses against a slow store buffer, back to back
        slow <= 1;
        sbp(0);
        sbp(1);
        sbp(0);
        iss(0, 1, 0);
        iss(0, 0, 0);
        slow <= 0;
        sbp(1);
        sbp(1);
        iss(1, 1, 0);
        iss(1, 0, 0);
        iss(1, 1, 1);
        iss(3, 1, 0);
        bus(1, `MRAD_OFF_STATUS, 0, 0, 32'h6, 32'h6);
        bus(0, `MRAD_OFF_STATUS, 32'h6, 4'h1, 0, 0);
        bus(1, `MRAD_OFF_STATUS, 0, 0, 32'h6, 32'h0);
        iss(2, 1, 0);
        bus(1, `MRAD_OFF_LAST, 0, 0, 32'h3FF, 32'h2FA);
        bus(0, `MRAD_OFF_CTRL, 32'h0, 4'h1, 0, 0);
        iss(2, 1, 0);
        bus(1, `MRAD_OFF_LAST, 0, 0, 32'h3FF, 32'h0FA);
        wrap_up;
    end
endmodule // mrad_decoder_test
